// ==== dma_cycle_sequencer.v ====
// two-channel (four sub-channel) dual-address dma cycle sequencer with request sampling
//
// Design decisions made here: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "dma_cycle_sequencer_consts.vh"

module dma_cycle_sequencer (
  input  wire        clock,       // 20 MHz system clock
  input  wire        nrst,        // asynchronous reset, active low
  input  wire        ce,          // clock enable, freezes all state when low
  input  wire [7:0]  addr,        // register byte address
  input  wire [31:0] wdata,       // register write data
  input  wire        wr,          // register write strobe
  input  wire        rd,          // register read strobe
  output reg  [31:0] rdata,       // read data, cycle after rd
  input  wire [1:0]  external_request_pin_n, // request pins of channel 0 and 1
  input  wire [3:0]  int_req,     // internal activation pulses per sub-channel
  input  wire        nmi,         // nonmaskable interrupt pulse
  input  wire        ext_hold,    // foreign master holds the released bus
  output wire        bus_own,     // sequencer owns the bus
  output wire        dma_read,    // read cycle in progress
  output wire        dma_write,   // write cycle in progress
  output wire        dma_dead,    // dead state in progress
  output wire [1:0]  cur_chan,    // sub-channel being served
  output reg  [1:0]  transfer_end_strobe_n, // end strobe per channel, low active
  output wire [3:0]  end_irq      // transfer end request per sub-channel
);

  // ****************************************************************
  // storage
  // ****************************************************************
  reg  [10:0] ctl_q [0:3];
  reg  [15:0] cnt_q [0:3];
  reg  [15:0] rld_q [0:3];
  reg  [7:0]  blk_q [0:3];
  reg  [2:0]  st_q;
  reg  [2:0]  st_d;
  reg  [1:0]  cur_q;
  reg  [7:0]  left_q;
  reg  [3:0]  latch_q;
  reg  [3:0]  wait_q;
  reg  [3:0]  high_q;
  reg  [3:0]  reopen_q;
  reg  [3:0]  samp_q;
  reg  [3:0]  int_q;
  reg  [3:0]  end_q;
  reg  [3:0]  pend;
  reg  [3:0]  act;
  reg  [3:0]  reopen_pt;
  integer     i;
  integer     n;

  // ****************************************************************
  // helpers
  // ****************************************************************
  // fixed priority pick: {valid, index}
  function [2:0] pick;
    input [3:0] p;
    begin
      if (p[0])
        pick = 3'h4;
      else if (p[1])
        pick = 3'h5;
      else if (p[2])
        pick = 3'h6;
      else if (p[3])
        pick = 3'h7;
      else
        pick = 3'h0;
    end
  endfunction

  // channel may transfer: enables plus full-mode pairing
  function enabled;
    input [10:0] c;
    input        b_slot;
    input        pair_full;
    begin
      enabled = c[`CTL_CHEN] & (~c[`CTL_FULL] | c[`CTL_MEN])
                & ~(b_slot & pair_full);
    end
  endfunction

  wire [2:0]  win     = pick(pend);
  wire        go      = (st_q == `ST_IDLE) & win[2] & ~ext_hold;
  wire [10:0] cc      = ctl_q[cur_q];
  wire        c_full  = cc[`CTL_FULL];
  wire        c_block = c_full & cc[`CTL_BLOCK];
  wire        c_burst = c_full & cc[`CTL_BURST] & ~cc[`CTL_BLOCK];
  wire        c_last  = (cnt_q[cur_q] == 16'h0001);
  wire        blk_end = (left_q == 8'h01);
  wire        fin     = c_block ? (blk_end & c_last) : c_last;
  wire        men_ok  = cc[`CTL_MEN] & ~nmi;

  // ****************************************************************
  // request qualification and acceptance points
  // ****************************************************************
  always @*
  begin
    pend      = 4'h0;
    act       = 4'h0;
    reopen_pt = 4'h0;
    for (n = 0; n < 4; n = n + 1)
    begin
      if (enabled(ctl_q[n], n[0], ctl_q[n & 2][`CTL_FULL]))
      begin
        if (ctl_q[n][`CTL_PINSRC])
          pend[n] = latch_q[n];
        else if (ctl_q[n][`CTL_FULL] & ~ctl_q[n][`CTL_BLOCK])
          pend[n] = 1'b1;
        else
          pend[n] = int_q[n];
      end
      if (cur_q == n[1:0])
      begin
        if (ctl_q[n][`CTL_FULL] & ctl_q[n][`CTL_BLOCK])
          reopen_pt[n] = (st_q == `ST_DEAD);
        else
          reopen_pt[n] = (st_q == `ST_WRITE);
      end
    end
    if (go)
      act[win[1:0]] = 1'b1;
  end

  // ****************************************************************
  // sequencer state machine
  // ****************************************************************
  always @*
  begin
    st_d = st_q;
    case (st_q)
      `ST_IDLE:
        if (go)
          st_d = `ST_READ;
      `ST_READ:
        st_d = `ST_WRITE;
      `ST_WRITE:
        if (c_block)
          st_d = blk_end ? `ST_DEAD : `ST_READ;
        else if (c_last)
          st_d = `ST_DEAD;
        else if (c_burst & men_ok)
          st_d = `ST_READ;
        else
          st_d = `ST_REL;
      `ST_DEAD:
        st_d = `ST_REL;
      `ST_REL:
        st_d = `ST_IDLE;
      default:
        st_d = `ST_IDLE;
    endcase
  end

  assign bus_own   = (st_q == `ST_READ) | (st_q == `ST_WRITE) | (st_q == `ST_DEAD);
  assign dma_read  = (st_q == `ST_READ);
  assign dma_write = (st_q == `ST_WRITE);
  assign dma_dead  = (st_q == `ST_DEAD);
  assign cur_chan  = cur_q;

  assign end_irq   = end_q & {ctl_q[3][`CTL_IRQEN], ctl_q[2][`CTL_IRQEN],
                              ctl_q[1][`CTL_IRQEN], ctl_q[0][`CTL_IRQEN]};

  // ****************************************************************
  // sequencer, block counter and strobe
  // ****************************************************************
  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      st_q                  <= `ST_IDLE;
      cur_q                 <= 2'h0;
      left_q                <= `BLK_RESET;
      transfer_end_strobe_n <= 2'h3;
    end
    else if (ce)
    begin
      st_q <= st_d;
      if (go)
      begin
        cur_q  <= win[1:0];
        left_q <= blk_q[win[1:0]];
      end
      else if (st_q == `ST_WRITE && c_block)
        left_q <= blk_end ? blk_q[cur_q] : left_q - 8'h01;
      transfer_end_strobe_n <= 2'h3;
      if (st_d == `ST_WRITE && fin && cc[`CTL_STROBE_EN])
        transfer_end_strobe_n[cur_q[1]] <= 1'b0;
    end
  end

  // ****************************************************************
  // registers and per-channel request state
  // ****************************************************************
  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      for (i = 0; i < 4; i = i + 1)
      begin
        ctl_q[i] <= `CTL_RESET;
        cnt_q[i] <= `CNT_RESET;
        rld_q[i] <= `CNT_RESET;
        blk_q[i] <= `BLK_RESET;
      end
      latch_q  <= 4'h0;
      wait_q   <= 4'h0;
      high_q   <= 4'h0;
      reopen_q <= 4'h0;
      samp_q   <= 4'h0;
      int_q    <= 4'h0;
      end_q    <= 4'h0;
    end
    else if (ce)
    begin
      for (i = 0; i < 4; i = i + 1)
      begin
        // nmi stops enabled burst channels only
        if (nmi && ctl_q[i][`CTL_FULL] && ctl_q[i][`CTL_BURST]
            && !ctl_q[i][`CTL_BLOCK] && ctl_q[i][`CTL_CHEN])
          ctl_q[i][`CTL_MEN] <= 1'b0;
        // counting at the write cycle of the served channel
        if (st_q == `ST_WRITE && cur_q == i[1:0])
        begin
          if (!c_block || blk_end)
          begin
            if (c_last)
            begin
              if (ctl_q[i][`CTL_REPEAT] && !ctl_q[i][`CTL_FULL])
                cnt_q[i] <= rld_q[i];
              else
              begin
                cnt_q[i]            <= 16'h0000;
                ctl_q[i][`CTL_CHEN] <= 1'b0;
                end_q[i]            <= 1'b1;
              end
            end
            else
              cnt_q[i] <= cnt_q[i] - 16'h0001;
          end
        end
        // software writes win over the hardware clear
        if (wr && addr == (`ADDR_CTL0A + {i[1:0], 2'b00}))
          ctl_q[i] <= wdata[10:0];
        if (wr && addr == (`ADDR_CNT0A + {i[1:0], 2'b00}))
        begin
          cnt_q[i] <= wdata[15:0];
          rld_q[i] <= wdata[15:0];
        end
        if (wr && addr == (`ADDR_BLK0A + {i[1:0], 2'b00}))
          blk_q[i] <= wdata[7:0];
        if (wr && addr == `ADDR_ENDCLR && wdata[i])
          end_q[i] <= 1'b0;
        // end flag set wins over the software clear
        if (st_q == `ST_WRITE && cur_q == i[1:0] && fin
            && !(ctl_q[i][`CTL_REPEAT] && !ctl_q[i][`CTL_FULL]))
          end_q[i] <= 1'b1;
        // internal request latch, set wins over activation clear
        if (int_req[i])
          int_q[i] <= 1'b1;
        else if (act[i] && !ctl_q[i][`CTL_PINSRC])
          int_q[i] <= 1'b0;
        // sampling opens one edge after the enabling write
        samp_q[i] <= ctl_q[i][`CTL_CHEN] & ctl_q[i][`CTL_PINSRC];
        if (!samp_q[i])
        begin
          latch_q[i]  <= 1'b0;
          wait_q[i]   <= 1'b0;
          high_q[i]   <= 1'b0;
          reopen_q[i] <= 1'b0;
        end
        else if (act[i])
        begin
          latch_q[i]  <= 1'b0;
          wait_q[i]   <= 1'b1;
          high_q[i]   <= 1'b0;
          reopen_q[i] <= 1'b0;
        end
        else if (wait_q[i])
        begin
          if (external_request_pin_n[i >> 1])
            high_q[i] <= 1'b1;
          if (reopen_pt[i] || reopen_q[i])
          begin
            if (!ctl_q[i][`CTL_EDGE] || high_q[i]
                || external_request_pin_n[i >> 1])
            begin
              wait_q[i]   <= 1'b0;
              reopen_q[i] <= 1'b0;
            end
            else
              reopen_q[i] <= 1'b1;
          end
        end
        else if (!external_request_pin_n[i >> 1])
          latch_q[i] <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // read port
  // ****************************************************************
  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      rdata <= 32'h00000000;
    else if (ce)
    begin
      rdata <= 32'h00000000;
      if (rd)
      begin
        if (addr <= `ADDR_CTL1B && addr[1:0] == 2'b00)
          rdata <= {21'h000000, ctl_q[addr[3:2]]};
        else if (addr >= `ADDR_CNT0A && addr <= `ADDR_CNT1B && addr[1:0] == 2'b00)
          rdata <= {16'h0000, cnt_q[addr[3:2]]};
        else if (addr >= `ADDR_BLK0A && addr <= `ADDR_BLK1B && addr[1:0] == 2'b00)
          rdata <= {24'h000000, blk_q[addr[3:2]]};
        else if (addr == `ADDR_STATUS)
          rdata <= {11'h000, left_q, st_q, cur_q, end_q, pend};
      end
    end
  end

endmodule

`default_nettype wire

// ==== dma_cycle_sequencer_consts.vh ====
// constants for the dma cycle sequencer: register map, fields, states
`ifndef DMA_CYCLE_SEQUENCER_CONSTS_VH
`define DMA_CYCLE_SEQUENCER_CONSTS_VH

// ****************************************************************
// register byte addresses (one 32-bit word each)
// ****************************************************************
`define ADDR_CTL0A     8'h00
`define ADDR_CTL0B     8'h04
`define ADDR_CTL1A     8'h08
`define ADDR_CTL1B     8'h0C
`define ADDR_CNT0A     8'h10
`define ADDR_CNT1B     8'h1C
`define ADDR_BLK0A     8'h20
`define ADDR_BLK1B     8'h2C
`define ADDR_STATUS    8'h30
`define ADDR_ENDCLR    8'h34

// ****************************************************************
// channel_control_word fields
// ****************************************************************
`define CTL_CHEN       0
`define CTL_MEN        1
`define CTL_IRQEN      2
`define CTL_ACKSEL     3
`define CTL_EDGE       4
`define CTL_REPEAT     5
`define CTL_STROBE_EN  6
`define CTL_FULL       7
`define CTL_BURST      8
`define CTL_BLOCK      9
`define CTL_PINSRC     10
`define CTL_WIDTH      11
`define CTL_RESET      11'h000

// ****************************************************************
// sequencer states
// ****************************************************************
`define ST_IDLE        3'h0
`define ST_READ        3'h1
`define ST_WRITE       3'h2
`define ST_DEAD        3'h3
`define ST_REL         3'h4

`define CNT_RESET      16'h0000
`define BLK_RESET      8'h00

`endif

// ==== dma_seq_checker.sv ====
// concurrent checks on the ports of the dma cycle sequencer
`timescale 1ns/1ps
`default_nettype none
module dma_seq_checker (
  input wire       clock,                 // system clock
  input wire       nrst,                  // reset, active low
  input wire       ext_hold,              // foreign master holds the bus
  input wire       bus_own,               // sequencer owns the bus
  input wire       dma_read,              // read cycle
  input wire       dma_write,             // write cycle
  input wire       dma_dead,              // dead state
  input wire [1:0] cur_chan,              // sub-channel served
  input wire [1:0] transfer_end_strobe_n  // end strobe per channel, low active
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  // ****************************************************************
  // sequences
  // ****************************************************************
  sequence unit_s;
    dma_read ##1 dma_write && !dma_read;
  endsequence
  sequence gap_s;
    !bus_own ##1 !bus_own;
  endsequence
  // ****************************************************************
  // properties
  // ****************************************************************
  unit_pair_a: assert property (dma_read |-> unit_s)
    else $error("read not followed by its write");
  write_cause_a: assert property (dma_write |-> $past(dma_read))
    else $error("write without read before it");
  dead_cause_a: assert property (dma_dead |-> $past(dma_write))
    else $error("dead state not after a write");
  dead_release_a: assert property (dma_dead |=> !bus_own)
    else $error("bus kept after dead state");
  release_gap_a: assert property ($fell(bus_own) |-> gap_s)
    else $error("grant gap shorter than two cycles");
  chan_hold_a: assert property (bus_own && $past(bus_own) |-> $stable(cur_chan))
    else $error("channel switched while bus owned");
  strobe_write_a: assert property (transfer_end_strobe_n != 2'b11 |-> dma_write)
    else $error("end strobe outside write cycle");
  strobe_dead_a: assert property (transfer_end_strobe_n != 2'b11 |=> dma_dead)
    else $error("no dead state after final unit");
  strobe_chan_a: assert property (!transfer_end_strobe_n[0] |-> !cur_chan[1])
    else $error("end strobe on wrong channel");
  hold_grant_a: assert property (ext_hold && !bus_own |=> !dma_read)
    else $error("grant while foreign master holds bus");
endmodule
bind dma_cycle_sequencer dma_seq_checker chk (
  .clock(clock),
  .nrst(nrst),
  .ext_hold(ext_hold),
  .bus_own(bus_own),
  .dma_read(dma_read),
  .dma_write(dma_write),
  .dma_dead(dma_dead),
  .cur_chan(cur_chan),
  .transfer_end_strobe_n(transfer_end_strobe_n)
);
`default_nettype wire

// ==== bus_peer.sv ====
// far side model: requesting peripheral and a foreign bus master
`timescale 1ns/1ps
`default_nettype none
module bus_peer (
  input  wire        clock,    // system clock
  input  wire        nrst,     // reset, active low
  input  wire        bus_own,  // sequencer owns the bus
  input  wire        pin_low,  // bench asks for a low request level
  output wire  [1:0] pin_n,    // request pins, low active
  output logic       ext_hold  // foreign master holds the bus
);
  logic own_q;
  // channel 1 pin idles high
  assign pin_n = {1'b1, ~pin_low};
  // takes one cycle of the bus after every release
  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      own_q <= 1'b0;
      ext_hold <= 1'b0;
    end
    else
    begin
      own_q <= bus_own;
      ext_hold <= own_q & ~bus_own;
    end
  end
endmodule
`default_nettype wire

// ==== dma_cycle_sequencer_test.sv ====
// self-checking bench for the dma cycle sequencer
`timescale 1ns/1ps
`default_nettype none
`include "dma_cycle_sequencer_consts.vh"
module dma_cycle_sequencer_test;
  logic        clock, nrst, wr, rd, nmi, pin_low, own_q;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata;
  logic [3:0]  int_req, end_irq;
  logic [1:0]  pin_n, cur_chan, end_strobe_n;
  logic        ext_hold, bus_own, dma_read, dma_write, dma_dead;
  logic [5:0]  log_q;
  int          failures, total_checks, n_wr, n_dead, n_rel, n_strobe, n_strobe1, cyc;

  dma_cycle_sequencer DUT (.clock(clock), .nrst(nrst), .ce(1'b1), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .external_request_pin_n(pin_n),
    .int_req(int_req), .nmi(nmi), .ext_hold(ext_hold), .bus_own(bus_own),
    .dma_read(dma_read), .dma_write(dma_write), .dma_dead(dma_dead),
    .cur_chan(cur_chan), .transfer_end_strobe_n(end_strobe_n), .end_irq(end_irq));
  bus_peer peer (.clock(clock), .nrst(nrst), .bus_own(bus_own), .pin_low(pin_low),
    .pin_n(pin_n), .ext_hold(ext_hold));

  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // ****************************************************************
  // activity monitor and timeout
  // ****************************************************************
  always @(posedge clock)
  begin
    cyc++;
    if (dma_write === 1'b1) n_wr++;
    if (dma_write === 1'b1) log_q <= {log_q[3:0], cur_chan};
    if (dma_dead === 1'b1) n_dead++;
    if (end_strobe_n[0] === 1'b0) n_strobe++;
    if (end_strobe_n[1] === 1'b0) n_strobe1++;
    if (own_q === 1'b1 && bus_own === 1'b0) n_rel++;
    own_q <= bus_own;
    if (cyc == 20000)
    begin
      failures++;
      finish_test();
    end
  end
  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr_reg(logic [7:0] a, logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(logic [7:0] a, logic [31:0] exp, string nm);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 chk(nm, rdata, exp);
  endtask
  task automatic pulse(logic [3:0] r, logic m);
    @(posedge clock);
    int_req <= r;
    nmi <= m;
    @(posedge clock);
    int_req <= 4'h0;
    nmi <= 1'b0;
  endtask
  task automatic settle();
    int q;
    q = 0;
    for (int n = 0; n < 3000 && q < 12; n++)
    begin
      @(posedge clock);
      q = (bus_own === 1'b0 && ext_hold === 1'b0) ? q + 1 : 0;
    end
  endtask
  task automatic wait_wr(int k);
    for (int n = 0; n < 500 && n_wr < k; n++) @(posedge clock);
  endtask
  task automatic clr();
    n_wr = 0;
    n_dead = 0;
    n_rel = 0;
    n_strobe = 0;
    n_strobe1 = 0;
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic test_regs();
    rd_chk(`ADDR_CTL1B, 32'h0000_0000, "ctl1b reset");
    wr_reg(`ADDR_CTL1B, 32'h0000_0010);
    rd_chk(`ADDR_CTL1B, 32'h0000_0010, "ctl1b readback");
    rd_chk(8'h40, 32'h0000_0000, "unmapped read");
    wr_reg(`ADDR_CTL1B, 32'h0000_0000);
    $display("test_regs done");
  endtask
  task automatic test_short();
    clr();
    wr_reg(`ADDR_CNT0A + 8'h04, 32'h0000_0002);
    wr_reg(`ADDR_CTL0B, 32'h0000_0045);
    pulse(4'h2, 1'b0);
    settle();
    chk("one unit writes", n_wr, 1);
    chk("one unit release", n_rel, 1);
    chk("no early dead", n_dead, 0);
    pulse(4'h2, 1'b0);
    settle();
    chk("final dead", n_dead, 1);
    chk("end strobe cycles", n_strobe, 1);
    chk("end request", end_irq, 4'h2);
    rd_chk(`ADDR_CTL0B, 32'h0000_0044, "enable cleared");
    wr_reg(`ADDR_ENDCLR, 32'h0000_0002);
    $display("test_short done");
  endtask
  task automatic test_prio();
    clr();
    wr_reg(`ADDR_CNT0A + 8'h04, 32'h0000_0001);
    wr_reg(`ADDR_CNT0A + 8'h08, 32'h0000_0001);
    wr_reg(`ADDR_CNT1B, 32'h0000_0001);
    wr_reg(`ADDR_CTL0B, 32'h0000_0001);
    wr_reg(`ADDR_CTL1A, 32'h0000_0001);
    wr_reg(`ADDR_CTL1B, 32'h0000_0001);
    pulse(4'hE, 1'b0);
    settle();
    chk("grant order", log_q, 6'b01_10_11);
    chk("release per unit", n_rel, 3);
    $display("test_prio done");
  endtask
  task automatic test_steal();
    clr();
    wr_reg(`ADDR_CNT0A, 32'h0000_0002);
    wr_reg(`ADDR_CTL0A, 32'h0000_0083);
    settle();
    chk("steal units", n_wr, 2);
    chk("steal releases", n_rel, 2);
    chk("steal dead", n_dead, 1);
    rd_chk(`ADDR_CTL0A, 32'h0000_0082, "steal end");
    $display("test_steal done");
  endtask
  task automatic test_repeat();
    clr();
    wr_reg(`ADDR_CNT1B, 32'h0000_0001);
    wr_reg(`ADDR_CTL1B, 32'h0000_0061);
    pulse(4'h8, 1'b0);
    settle();
    chk("repeat unit", n_wr, 1);
    chk("repeat dead", n_dead, 1);
    chk("repeat strobe", n_strobe1, 1);
    chk("strobe other pin", n_strobe, 0);
    rd_chk(`ADDR_CNT1B, 32'h0000_0001, "repeat reload");
    rd_chk(`ADDR_CTL1B, 32'h0000_0061, "repeat keeps enable");
    wr_reg(`ADDR_CTL1B, 32'h0000_0000);
    $display("test_repeat done");
  endtask
  task automatic test_burst();
    clr();
    wr_reg(`ADDR_CNT0A, 32'h0000_0004);
    wr_reg(`ADDR_CTL0A, 32'h0000_0183);
    settle();
    chk("burst units", n_wr, 4);
    chk("burst one release", n_rel, 1);
    rd_chk(`ADDR_CTL0A, 32'h0000_0182, "burst end");
    clr();
    wr_reg(`ADDR_CNT0A, 32'h0000_0006);
    wr_reg(`ADDR_CTL0A, 32'h0000_0183);
    wait_wr(1);
    pulse(4'h0, 1'b1);
    settle();
    chk("burst suspended", n_wr < 6, 1);
    rd_chk(`ADDR_CTL0A, 32'h0000_0181, "master cleared");
    wr_reg(`ADDR_CTL0A, 32'h0000_0183);
    settle();
    chk("burst resumed", n_wr, 6);
    wr_reg(`ADDR_CTL0A, 32'h0000_0000);
    $display("test_burst done");
  endtask
  task automatic test_block();
    clr();
    wr_reg(`ADDR_CNT0A + 8'h08, 32'h0000_0002);
    wr_reg(`ADDR_BLK0A + 8'h08, 32'h0000_0003);
    wr_reg(`ADDR_CTL1A, 32'h0000_0283);
    pulse(4'h4, 1'b0);
    wait_wr(1);
    pulse(4'h0, 1'b1);
    settle();
    chk("block units", n_wr, 3);
    chk("block dead", n_dead, 1);
    chk("block release", n_rel, 1);
    rd_chk(`ADDR_CTL1A, 32'h0000_0283, "nmi no effect");
    wr_reg(`ADDR_CTL1A, 32'h0000_0000);
    $display("test_block done");
  endtask
  task automatic test_pin();
    clr();
    wr_reg(`ADDR_CNT0A + 8'h04, 32'h0000_0003);
    wr_reg(`ADDR_CTL0B, 32'h0000_0419); // ack select set for pin channel
    pin_low <= 1'b1;
    settle();
    chk("edge one unit", n_wr, 1);
    pin_low <= 1'b0;
    settle();
    pin_low <= 1'b1;
    settle();
    chk("edge second unit", n_wr, 2);
    pin_low <= 1'b0;
    clr();
    wr_reg(`ADDR_CNT0A + 8'h04, 32'h0000_0003);
    wr_reg(`ADDR_CTL0B, 32'h0000_0409);
    pin_low <= 1'b1;
    settle();
    chk("level units", n_wr, 3);
    chk("level releases", n_rel, 3);
    pin_low <= 1'b0;
    $display("test_pin done");
  endtask
  task automatic finish_test();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    nrst = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    nmi = 1'b0;
    pin_low = 1'b0;
    addr = 8'h00;
    wdata = 32'h0000_0000;
    int_req = 4'h0;
    failures = 0;
    total_checks = 0;
    cyc = 0;
    clr();
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    test_regs();
    test_short();
    test_prio();
    test_steal();
    test_repeat();
    test_burst();
    test_block();
    test_pin();
    finish_test();
  end
endmodule
`default_nettype wire
